// ==== design/lsf_status_regs.sv ====
// Lane status flag bank with paging, threshold and interrupt logic.
`timescale 1ns/1ps
module lsf_status_regs
  import lsf_pkg::*;
#(
  parameter int NUM_LINKS = LSF_NUM_LINKS
)
(
  // Clock, reset and clock enable.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic coreCe,
  // Register port.
  input wire lsf_bus_req_s busReq,
  output logic [7:0] rdData,
  // Live receiver state per link.
  input wire lsf_lane_s [NUM_LINKS-1:0] lane3Live,
  input wire lsf_lane_s [NUM_LINKS-1:0] lane4Live,
  input wire lsf_errcnt_s [NUM_LINKS-1:0] lane4Cnt,
  // Interrupt.
  output logic irqOut
);

  lsf_top_state_s s_q;
  lsf_top_state_s s_d;

  lsf_lane_s [NUM_LINKS-1:0] lane3Flags;
  lsf_lane_s [NUM_LINKS-1:0] lane4Flags;
  lsf_errflag_s [NUM_LINKS-1:0] lane4Err;

  lsf_lane_s sel3;
  lsf_lane_s sel4;
  lsf_errflag_s selErr;
  logic [7:0] flagsA;
  logic [7:0] flagsB;

  logic [LSF_NUM_EV-1:0] evtLevel;
  logic [LSF_NUM_EV-1:0] evtRise;

  logic wrHit;
  logic rdHit;

  // Cycle in which the state register really takes a new value.
  logic enabledCyc;

  // Sampling and threshold compare of the lane state of every link.
  lsf_flag_sampler #(
    .NUM_LINKS(NUM_LINKS)
  ) uSampler (
    .core_clk(core_clk),
    .reset(reset),
    .coreCe(coreCe),
    .errorCountThreshold(s_q.thresh),
    .lane3Live(lane3Live),
    .lane4Live(lane4Live),
    .lane4Cnt(lane4Cnt),
    .lane3Flags(lane3Flags),
    .lane4Flags(lane4Flags),
    .lane4Err(lane4Err)
  );

  // Packs the lane 3 flag register; upper error bits are not kept here.
  function automatic logic [7:0] packFlagsA(lsf_lane_s l);
    logic [7:0] v;
    v = LSF_RST_FLAGS;
    v[LSF_BIT_DESKEW] = l.deskewOk;
    v[LSF_BIT_ALIGN] = l.initialAlignOk;
    v[LSF_BIT_CKSUM] = l.checksumOk;
    v[LSF_BIT_FRAME] = l.frameLocked;
    v[LSF_BIT_CGRP] = l.codegroupLocked;
    return v;
  endfunction

  // Packs the lane 4 flag register; bits 1 and 0 always read as zero.
  function automatic logic [7:0] packFlagsB(lsf_lane_s l, lsf_errflag_s e);
    logic [7:0] v;
    v = LSF_RST_FLAGS;
    v[LSF_BIT_DISP] = e.dispErr;
    v[LSF_BIT_INVALID] = e.invalidSym;
    v[LSF_BIT_STRAY] = e.strayCtrl;
    v[LSF_BIT_DESKEW] = l.deskewOk;
    v[LSF_BIT_ALIGN] = l.initialAlignOk;
    v[LSF_BIT_CKSUM] = l.checksumOk;
    return v;
  endfunction

  // Picks the link named by the page register.  A page beyond the last
  // link selects nothing, so software sees all flags low rather than a
  // wrapped-around link.
  always_comb
  begin
    sel3 = '0;
    sel4 = '0;
    selErr = '0;
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      if (s_q.page == 8'(i))
      begin
        sel3 = lane3Flags[i];
        sel4 = lane4Flags[i];
        selErr = lane4Err[i];
      end
    end
  end

  assign flagsA = packFlagsA(sel3);
  assign flagsB = packFlagsB(sel4, selErr);

  // Event levels cover all links, so a page change raises no false event.
  always_comb
  begin
    evtLevel = '0;
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      evtLevel[LSF_EV_L3_DROP] = evtLevel[LSF_EV_L3_DROP] |
        ~&lane3Flags[i];
      evtLevel[LSF_EV_L4_DROP] = evtLevel[LSF_EV_L4_DROP] |
        ~&lane4Flags[i];
      evtLevel[LSF_EV_DISP] = evtLevel[LSF_EV_DISP] |
        lane4Err[i].dispErr;
      evtLevel[LSF_EV_INVALID] = evtLevel[LSF_EV_INVALID] |
        lane4Err[i].invalidSym;
      evtLevel[LSF_EV_STRAY] = evtLevel[LSF_EV_STRAY] |
        lane4Err[i].strayCtrl;
    end
  end

  // One-cycle pulses when a level turns bad.
  lsf_event_detect #(
    .W(LSF_NUM_EV)
  ) uEvents (
    .core_clk(core_clk),
    .reset(reset),
    .coreCe(coreCe),
    .level(evtLevel),
    .rise(evtRise)
  );

  assign wrHit = busReq.wrStrobe;
  assign rdHit = busReq.rdStrobe;
  assign enabledCyc = coreCe && !reset;

  // Register writes, read mux and sticky interrupt status.
  always_comb
  begin
    s_d = s_q;
    s_d.rdData = '0;
    // Writes to writable registers; the flag offsets fall through.
    if (wrHit)
    begin
      if (busReq.addr == LSF_OFF_PAGE)
      begin
        s_d.page = busReq.wrData;
      end
      else if (busReq.addr == LSF_OFF_THRESH)
      begin
        s_d.thresh = busReq.wrData;
      end
      else if (busReq.addr == LSF_OFF_IRQ_ST)
      begin
        s_d.irqSt = s_q.irqSt & ~busReq.wrData[LSF_NUM_EV-1:0];
      end
      else if (busReq.addr == LSF_OFF_IRQ_MASK)
      begin
        s_d.irqMask = busReq.wrData[LSF_NUM_EV-1:0];
      end
      else
      begin
        s_d.page = s_q.page;
      end
    end
    // Set is applied after the clear so a new event is never lost.
    s_d.irqSt = s_d.irqSt | evtRise;
    // Read data stand for one cycle only and are zero otherwise.
    if (rdHit)
    begin
      if (busReq.addr == LSF_OFF_FLAGS_A)
      begin
        s_d.rdData = flagsA;
      end
      else if (busReq.addr == LSF_OFF_FLAGS_B)
      begin
        s_d.rdData = flagsB;
      end
      else if (busReq.addr == LSF_OFF_PAGE)
      begin
        s_d.rdData = s_q.page;
      end
      else if (busReq.addr == LSF_OFF_THRESH)
      begin
        s_d.rdData = s_q.thresh;
      end
      else if (busReq.addr == LSF_OFF_IRQ_ST)
      begin
        s_d.rdData = {3'h0, s_q.irqSt};
      end
      else if (busReq.addr == LSF_OFF_IRQ_MASK)
      begin
        s_d.rdData = {3'h0, s_q.irqMask};
      end
      else
      begin
        s_d.rdData = '0;
      end
    end
    // Level interrupt from the next status, so it moves with the bits.
    s_d.irq = |(s_d.irqSt & s_d.irqMask);
  end

  // State register; the clock enable freezes everything but reset.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s_q.page <= LSF_RST_PAGE;
      s_q.thresh <= LSF_RST_THRESH;
      s_q.irqSt <= LSF_RST_IRQ;
      s_q.irqMask <= LSF_RST_IRQ;
      s_q.rdData <= LSF_RST_FLAGS;
      s_q.irq <= 1'b0;
    end
    else if (coreCe)
    begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rdData;
  assign irqOut = s_q.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset || !coreCe);

  // Read of one flag bit returns the selected link's value a cycle later.
  property p_flag_bit(logic [11:0] off, int b, logic v);
    enabledCyc && busReq.rdStrobe && busReq.addr == off |=>
      rdData[b] == $past(v);
  endproperty

  sequence s_rd_a;
    enabledCyc && busReq.rdStrobe && busReq.addr == LSF_OFF_FLAGS_A;
  endsequence

  // A read of the lane 3 flags while the page names no link.
  sequence s_rd_a_nolink;
    s_rd_a ##0 s_q.page >= 8'(NUM_LINKS);
  endsequence

  // A lane 3 drop event in a cycle that really updates the state.
  sequence s_l3_drop;
    enabledCyc && evtRise[LSF_EV_L3_DROP];
  endsequence

  sequence s_event;
    enabledCyc && evtRise[LSF_EV_DISP] && s_q.irqMask[LSF_EV_DISP];
  endsequence

  a_deskew3_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_A, LSF_BIT_DESKEW, sel3.deskewOk))
    else $error("Lane 3 deskew bit wrong.");
  a_align3_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_A, LSF_BIT_ALIGN, sel3.initialAlignOk))
    else $error("Lane 3 alignment bit wrong.");
  a_cksum3_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_A, LSF_BIT_CKSUM, sel3.checksumOk))
    else $error("Lane 3 checksum bit wrong.");
  a_frame3_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_A, LSF_BIT_FRAME, sel3.frameLocked))
    else $error("Lane 3 frame bit wrong.");
  a_cgrp3_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_A, LSF_BIT_CGRP, sel3.codegroupLocked))
    else $error("Lane 3 code group bit wrong.");
  a_disp4_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_B, LSF_BIT_DISP, selErr.dispErr))
    else $error("Lane 4 disparity bit wrong.");
  a_invalid4_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_B, LSF_BIT_INVALID, selErr.invalidSym))
    else $error("Lane 4 invalid symbol bit wrong.");
  a_stray4_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_B, LSF_BIT_STRAY, selErr.strayCtrl))
    else $error("Lane 4 stray control bit wrong.");
  a_deskew4_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_B, LSF_BIT_DESKEW, sel4.deskewOk))
    else $error("Lane 4 deskew bit wrong.");
  a_align4_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_B, LSF_BIT_ALIGN, sel4.initialAlignOk))
    else $error("Lane 4 alignment bit wrong.");
  a_cksum4_bit: assert property (
    p_flag_bit(LSF_OFF_FLAGS_B, LSF_BIT_CKSUM, sel4.checksumOk))
    else $error("Lane 4 checksum bit wrong.");
  a_page_link0: assert property (
    s_rd_a ##0 s_q.page == 8'h00 |=>
      rdData[LSF_BIT_DESKEW] == $past(lane3Flags[0].deskewOk))
    else $error("Page 0 read did not return link 0.");
  a_flag_readonly: assert property (
    enabledCyc && busReq.wrStrobe && busReq.addr == LSF_OFF_FLAGS_B |=>
      s_q.page == $past(s_q.page) && s_q.thresh == $past(s_q.thresh))
    else $error("Write to flag register changed state.");
  a_irq_follow: assert property (
    s_event |=> irqOut && s_q.irqSt[LSF_EV_DISP])
    else $error("Unmasked event did not raise the interrupt.");

  // Paging corner cases, the sticky status and the idle read data.
  a_page_lastlink: assert property (
    s_rd_a ##0 s_q.page == 8'(NUM_LINKS - 1) |=>
      rdData[LSF_BIT_DESKEW] == $past(lane3Flags[NUM_LINKS-1].deskewOk))
    else $error("Last page read did not return the last link.");
  a_page_nolink: assert property (
    s_rd_a_nolink |=> rdData == 8'h00)
    else $error("Page without a link returned nonzero flags.");
  a_drop_sticky: assert property (
    s_l3_drop |=> s_q.irqSt[LSF_EV_L3_DROP])
    else $error("Lane 3 drop event did not set its status bit.");
  a_rd_idle: assert property (
    enabledCyc && !busReq.rdStrobe |=> rdData == 8'h00)
    else $error("Read data did not fall back to zero.");

endmodule // lsf_status_regs

// ==== design/lsf_pkg.sv ====
// Shared constants, layouts and carrier types of the lane status flag bank.
package lsf_pkg;

  // Bus widths and link count.
  localparam int LSF_ADDR_W = 12;
  localparam int LSF_DATA_W = 8;
  localparam int LSF_NUM_LINKS = 2;

  // Register offsets.
  localparam logic [11:0] LSF_OFF_PAGE = 12'h300;
  localparam logic [11:0] LSF_OFF_FLAGS_A = 12'h4b3;
  localparam logic [11:0] LSF_OFF_FLAGS_B = 12'h4b4;
  localparam logic [11:0] LSF_OFF_THRESH = 12'h4c0;
  localparam logic [11:0] LSF_OFF_IRQ_ST = 12'h4c1;
  localparam logic [11:0] LSF_OFF_IRQ_MASK = 12'h4c2;

  // Bit positions inside the two lane flag registers.
  localparam int LSF_BIT_DISP = 7;
  localparam int LSF_BIT_INVALID = 6;
  localparam int LSF_BIT_STRAY = 5;
  localparam int LSF_BIT_DESKEW = 4;
  localparam int LSF_BIT_ALIGN = 3;
  localparam int LSF_BIT_CKSUM = 2;
  localparam int LSF_BIT_FRAME = 1;
  localparam int LSF_BIT_CGRP = 0;

  // Interrupt status bit positions.
  localparam int LSF_EV_L3_DROP = 0;
  localparam int LSF_EV_L4_DROP = 1;
  localparam int LSF_EV_DISP = 2;
  localparam int LSF_EV_INVALID = 3;
  localparam int LSF_EV_STRAY = 4;
  localparam int LSF_NUM_EV = 5;

  // Reset values.
  localparam logic [7:0] LSF_RST_FLAGS = 8'h00;
  localparam logic [7:0] LSF_RST_PAGE = 8'h00;
  localparam logic [7:0] LSF_RST_THRESH = 8'h01;
  localparam logic [4:0] LSF_RST_IRQ = 5'h00;

  // Live synchronisation state of one lane, one means achieved.
  typedef struct packed {
    logic deskewOk;
    logic initialAlignOk;
    logic checksumOk;
    logic frameLocked;
    logic codegroupLocked;
  } lsf_lane_s;

  // Running error counts of one lane.
  typedef struct packed {
    logic [7:0] disparity;
    logic [7:0] invalidSymbol;
    logic [7:0] strayControl;
  } lsf_errcnt_s;

  // Threshold comparison results of one lane.
  typedef struct packed {
    logic dispErr;
    logic invalidSym;
    logic strayCtrl;
  } lsf_errflag_s;

  // Register port request.
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } lsf_bus_req_s;

  // Software-visible state of the top module.
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] thresh;
    logic [4:0] irqSt;
    logic [4:0] irqMask;
    logic [7:0] rdData;
    logic irq;
  } lsf_top_state_s;

endpackage

// ==== design/lsf_event_detect.sv ====
// Rising edge detector over a vector of event levels.
`timescale 1ns/1ps
module lsf_event_detect
  import lsf_pkg::*;
#(
  parameter int W = 5
)
(
  // Clock and control.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic coreCe,
  // Levels in, one-cycle rises out.
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] prev;
  } lsf_edge_state_s;

  lsf_edge_state_s s_q;
  lsf_edge_state_s s_d;

  // Remember the last level so a rise shows for exactly one enabled cycle.
  always_comb
  begin
    s_d = s_q;
    s_d.prev = level;
  end

  always_ff @(posedge core_clk)
  begin
    // Starting high keeps levels that are bad straight out of reset, such
    // as the lost-lock flags, from firing a false event.
    if (reset)
      s_q <= '1;
    else if (coreCe)
      s_q <= s_d;
  end

  // A rise is only reported while the clock enable lets it be consumed.
  assign rise = level & ~s_q.prev & {W{coreCe}};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset || !coreCe);

  a_rise_single: assert property (rise[0] |=> !rise[0])
    else $error("Event rise lasted longer than one cycle.");

endmodule // lsf_event_detect

// ==== design/lsf_flag_sampler.sv ====
// Per-link sampling of lane state and threshold comparison of error counts.
`timescale 1ns/1ps
module lsf_flag_sampler
  import lsf_pkg::*;
#(
  parameter int NUM_LINKS = LSF_NUM_LINKS
)
(
  // Clock and control.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic coreCe,
  input wire logic [7:0] errorCountThreshold,
  // Live receiver state per link.
  input wire lsf_lane_s [NUM_LINKS-1:0] lane3Live,
  input wire lsf_lane_s [NUM_LINKS-1:0] lane4Live,
  input wire lsf_errcnt_s [NUM_LINKS-1:0] lane4Cnt,
  // Registered flags per link.
  output lsf_lane_s [NUM_LINKS-1:0] lane3Flags,
  output lsf_lane_s [NUM_LINKS-1:0] lane4Flags,
  output lsf_errflag_s [NUM_LINKS-1:0] lane4Err
);

  typedef struct packed {
    lsf_lane_s [NUM_LINKS-1:0] l3;
    lsf_lane_s [NUM_LINKS-1:0] l4;
    lsf_errflag_s [NUM_LINKS-1:0] err;
  } lsf_smp_state_s;

  lsf_smp_state_s s_q;
  lsf_smp_state_s s_d;

  // Same compare for all three counters; equality already counts as over.
  function automatic logic atOrAbove(logic [7:0] cnt, logic [7:0] thr);
    return cnt >= thr;
  endfunction

  // Flags follow the live state every enabled cycle, nothing is latched.
  always_comb
  begin
    s_d = s_q;
    for (int i = 0; i < NUM_LINKS; i++)
    begin
      s_d.l3[i] = lane3Live[i];
      s_d.l4[i] = lane4Live[i];
      s_d.err[i].dispErr =
        atOrAbove(lane4Cnt[i].disparity, errorCountThreshold);
      s_d.err[i].invalidSym =
        atOrAbove(lane4Cnt[i].invalidSymbol, errorCountThreshold);
      s_d.err[i].strayCtrl =
        atOrAbove(lane4Cnt[i].strayControl, errorCountThreshold);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      s_q <= '0;
    else if (coreCe)
      s_q <= s_d;
  end

  assign lane3Flags = s_q.l3;
  assign lane4Flags = s_q.l4;
  assign lane4Err = s_q.err;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset || !coreCe);

  a_disp_thresh: assert property (
    coreCe && !reset |=> lane4Err[0].dispErr ==
      $past(lane4Cnt[0].disparity >= errorCountThreshold))
    else $error("Disparity flag disagrees with threshold compare.");
  a_invalid_thresh: assert property (
    coreCe && !reset |=> lane4Err[0].invalidSym ==
      $past(lane4Cnt[0].invalidSymbol >= errorCountThreshold))
    else $error("Invalid symbol flag disagrees with threshold compare.");
  a_stray_thresh: assert property (
    coreCe && !reset |=> lane4Err[0].strayCtrl ==
      $past(lane4Cnt[0].strayControl >= errorCountThreshold))
    else $error("Stray control flag disagrees with threshold compare.");

endmodule // lsf_flag_sampler

// ==== tb/lsf_tx_model.sv ====
// Behavioural transmitter side that drives live lane state and counts.
`timescale 1ns/1ps
module lsf_tx_model
  import lsf_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Lane state toward the receiver.
  output lsf_lane_s [1:0] lane3Live,
  output lsf_lane_s [1:0] lane4Live,
  output lsf_errcnt_s [1:0] lane4Cnt
);
  // Links start out of sync with no errors counted.
  lsf_lane_s [1:0] l3Next = '0;
  lsf_lane_s [1:0] l4Next = '0;
  lsf_errcnt_s [1:0] cntNext = '0;

  // New link state lands at the next edge, so callers never race it.
  task automatic set_link(input int link, input lsf_lane_s l3,
    input lsf_lane_s l4, input lsf_errcnt_s cnt);
    l3Next[link] <= l3;
    l4Next[link] <= l4 | 5'h03; // Unused lane 4 locks idle high.
    cntNext[link] <= cnt;
  endtask

  // Drive the receiver just after each rising edge.
  always @(posedge core_clk)
  begin
    lane3Live <= l3Next;
    lane4Live <= l4Next;
    lane4Cnt <= cntNext;
  end
endmodule // lsf_tx_model

// ==== tb/test_serial_lane_status_flags.sv ====
// Self-checking bench of the lane status flag bank.
`timescale 1ns/1ps
module test_serial_lane_status_flags
  import lsf_pkg::*;
;
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] thr;
    lsf_lane_s l3;
    lsf_lane_s l4;
    lsf_errcnt_s cnt;
    logic [7:0] expA;
    logic [7:0] expB;
  } lsf_tb_row_s;

  logic core_clk;
  logic reset;
  logic coreCe;
  lsf_bus_req_s busReq;
  logic [7:0] rdData;
  logic irqOut;
  lsf_lane_s [1:0] lane3Live;
  lsf_lane_s [1:0] lane4Live;
  lsf_errcnt_s [1:0] lane4Cnt;
  lsf_tb_row_s rows [6];
  int err_count = 0;
  int cmp_count = 0;

  lsf_status_regs #(.NUM_LINKS(2)) DUT (
    .core_clk(core_clk), .reset(reset), .coreCe(coreCe),
    .busReq(busReq), .rdData(rdData),
    .lane3Live(lane3Live), .lane4Live(lane4Live), .lane4Cnt(lane4Cnt),
    .irqOut(irqOut));

  lsf_tx_model txModel (
    .core_clk(core_clk), .lane3Live(lane3Live),
    .lane4Live(lane4Live), .lane4Cnt(lane4Cnt));

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    busReq.wrStrobe <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd(input logic [11:0] a, input logic [7:0] e,
    input string n);
    @(posedge core_clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    busReq.rdStrobe <= 1'b0;
    #1;
    chk(n, e, rdData);
  endtask

  // Bounded wait for the interrupt level; a hang ends the run.
  task automatic wait_irq(input logic v);
    int k;
    // Step off the edge so the level is read once it has settled.
    #1;
    for (k = 0; k < 10; k++)
    begin
      if (irqOut === v)
        break;
      @(posedge core_clk);
      #1;
    end
    chk("irqOut", {7'h00, v}, {7'h00, irqOut});
    if (irqOut !== v)
      final_report();
  endtask

  task automatic quiet_links();
    @(posedge core_clk);
    txModel.set_link(0, 5'h1f, 5'h1f, 24'h000000);
    txModel.set_link(1, 5'h1f, 5'h1f, 24'h000000);
    repeat (3) @(posedge core_clk);
  endtask

  initial
  begin
    // Page, threshold, lane 3, lane 4, counts, flags A and B expected.
    rows[0] = '{8'h00, 8'h01, 5'h1f, 5'h1f, 24'h000000, 8'h1f, 8'h1c};
    rows[1] = '{8'h00, 8'h05, 5'h15, 5'h0b, 24'h050406, 8'h15, 8'ha8};
    rows[2] = '{8'h01, 8'h05, 5'h0a, 5'h13, 24'h00ff00, 8'h0a, 8'h50};
    rows[3] = '{8'h00, 8'h00, 5'h1f, 5'h1f, 24'h000000, 8'h1f, 8'hfc};
    rows[4] = '{8'h02, 8'h01, 5'h1f, 5'h1f, 24'hffffff, 8'h00, 8'h00};
    rows[5] = '{8'h01, 8'hff, 5'h1f, 5'h00, 24'hfeff00, 8'h1f, 8'h40};
    core_clk = 1'b0;
    reset = 1'b1;
    coreCe = 1'b1;
    busReq = '0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    // Reset values of every register.
    rd(LSF_OFF_FLAGS_A, 8'h00, "flagsA reset");
    rd(LSF_OFF_FLAGS_B, 8'h00, "flagsB reset");
    rd(LSF_OFF_PAGE, 8'h00, "page reset");
    rd(LSF_OFF_THRESH, 8'h01, "thresh reset");
    rd(LSF_OFF_IRQ_ST, 8'h00, "status reset");
    rd(LSF_OFF_IRQ_MASK, 8'h00, "mask reset");
    $display("test reset done");
    // The other link carries the inverse state to expose paging faults.
    foreach (rows[i])
    begin
      wr(LSF_OFF_THRESH, rows[i].thr);
      wr(LSF_OFF_PAGE, rows[i].page);
      txModel.set_link(rows[i].page[0], rows[i].l3, rows[i].l4,
        rows[i].cnt);
      txModel.set_link(!rows[i].page[0], ~rows[i].l3, ~rows[i].l4,
        ~rows[i].cnt);
      repeat (3) @(posedge core_clk);
      rd(LSF_OFF_FLAGS_A, rows[i].expA, "flagsA");
      rd(LSF_OFF_FLAGS_B, rows[i].expB, "flagsB");
      wr(LSF_OFF_FLAGS_B, ~rows[i].expB);
      wr(LSF_OFF_FLAGS_A, ~rows[i].expA);
      rd(LSF_OFF_FLAGS_B, rows[i].expB, "flagsB after write");
      rd(LSF_OFF_FLAGS_A, rows[i].expA, "flagsA after write");
      $display("test row %0d done", i);
    end
    // Unmapped read gives zero and read data fall back after one cycle.
    rd(12'h123, 8'h00, "unmapped read");
    rd(LSF_OFF_PAGE, 8'h01, "page readback");
    @(posedge core_clk);
    #1;
    chk("rdData idle", 8'h00, rdData);
    $display("test bus done");
    // Disparity event: raise, mask, unmask and clear.
    wr(LSF_OFF_PAGE, 8'h00);
    wr(LSF_OFF_THRESH, 8'h10);
    quiet_links();
    wr(LSF_OFF_IRQ_ST, 8'h1f);
    wr(LSF_OFF_IRQ_MASK, 8'h04);
    rd(LSF_OFF_IRQ_ST, 8'h00, "status cleared");
    wait_irq(1'b0);
    txModel.set_link(1, 5'h1f, 5'h1f, 24'h100000);
    wait_irq(1'b1);
    rd(LSF_OFF_IRQ_ST, 8'h04, "status disparity");
    wr(LSF_OFF_IRQ_MASK, 8'h00);
    wait_irq(1'b0);
    wr(LSF_OFF_IRQ_MASK, 8'h04);
    wait_irq(1'b1);
    wr(LSF_OFF_IRQ_ST, 8'h04);
    wait_irq(1'b0);
    // A lane 3 lock drop raises its own sticky bit.
    txModel.set_link(0, 5'h0f, 5'h1f, 24'h000000);
    repeat (4) @(posedge core_clk);
    rd(LSF_OFF_IRQ_ST, 8'h01, "status lane3 drop");
    $display("test interrupt done");
    // Clock enable low freezes sampling; the read sees the old value.
    quiet_links();
    rd(LSF_OFF_FLAGS_A, 8'h1f, "flagsA before freeze");
    @(posedge core_clk);
    coreCe <= 1'b0;
    txModel.set_link(0, 5'h03, 5'h1f, 24'h000000);
    repeat (4) @(posedge core_clk);
    coreCe <= 1'b1;
    busReq <= '{LSF_OFF_FLAGS_A, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    busReq.rdStrobe <= 1'b0;
    #1;
    chk("flagsA frozen", 8'h1f, rdData);
    rd(LSF_OFF_FLAGS_A, 8'h03, "flagsA live");
    $display("test freeze done");
    // Second reset in mid-run restores the writable registers.
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(LSF_OFF_THRESH, 8'h01, "thresh after reset");
    rd(LSF_OFF_IRQ_MASK, 8'h00, "mask after reset");
    rd(LSF_OFF_PAGE, 8'h00, "page after reset");
    rd(LSF_OFF_IRQ_ST, 8'h00, "status after reset");
    $display("test second reset done");
    final_report();
  end
endmodule // test_serial_lane_status_flags
